// ===== hdl/sps_top.sv
// pin-state manager for an spi slave with select and attention lines
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_four_wire, // 1: four-signal link
  input wire logic i_cfg_done, // internal configuration finished
  input wire logic i_req, // slave wants master attention
  input wire logic i_psave_req, // enter power saving
  input wire logic i_sck, // serial clock pin
  input wire logic i_mosi, // master-to-slave data pin
  input wire logic i_slave_select_line, // select pin, low active
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [`SPS_DW-1:0] i_tx_data,
  output logic o_rx_valid,
  output logic [`SPS_DW-1:0] o_rx_data,
  output logic o_miso, // serial output pin
  output logic o_miso_oe,
  output logic o_slave_select_line, // slave drive value
  output logic o_slave_select_line_oe,
  output logic o_attn_n, // attention line, low active
  output logic o_attn_oe,
  output sps_pkg::sps_state_t o_state
);
  import sps_pkg::*;

  // all state in one packed struct
  typedef struct packed {
    sps_state_t fsm; // single state register
    logic [1:0] sck_s; // sck synchroniser
    logic [1:0] mosi_s;
    logic [1:0] ss_s; // own select pin synchroniser
    logic sck_d; // previous synced sck for edge find
    logic [`SPS_CNT_W-1:0] win; // request window count
    logic [2:0] bitc; // bit position in byte
    logic [`SPS_DW-1:0] rx_sh;
    logic [`SPS_DW-1:0] tx_sh;
    logic rx_v;
    logic [`SPS_DW-1:0] rx_d;
    logic miso;
    logic miso_oe;
    logic ss_o;
    logic ss_oe;
    logic attn;
    logic attn_oe;
  } sps_st_t;

  sps_st_t st;
  sps_st_t next_st;
  logic buf_valid;
  logic [`SPS_DW-1:0] buf_data;
  logic buf_take;
  logic sel; // synced select asserted
  logic rise;
  logic fall;

  // word buffer so a late consumer loses no transmit word
  sps_buf u_buf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_tx_ready),
    .i_in_data(i_tx_data),
    .o_out_valid(buf_valid),
    .i_out_ready(buf_take),
    .o_out_data(buf_data)
  );

  // serial output enable decoded from state only, never from other logic
  function automatic logic miso_allowed(input sps_state_t s);
    return (s == SPS_SEL);
  endfunction

  // combinational derivations from second synchroniser stage only
  always_comb begin
    sel = !st.ss_s[1];
    rise = st.sck_s[1] && !st.sck_d;
    fall = !st.sck_s[1] && st.sck_d;
    // release the head word once its last bit is on the way out
    buf_take = (st.fsm == SPS_SEL) && fall && (st.bitc == `SPS_BIT_LAST);
  end

  // next-state and pin logic
  always_comb begin
    next_st = st;
    next_st.sck_s = {st.sck_s[0], i_sck};
    next_st.mosi_s = {st.mosi_s[0], i_mosi};
    next_st.ss_s = {st.ss_s[0], i_slave_select_line};
    next_st.sck_d = st.sck_s[1];
    next_st.rx_v = 1'b0;
    unique case (st.fsm)
      SPS_INIT: begin
        if (i_cfg_done) begin
          next_st.fsm = SPS_DESEL;
        end
      end
      SPS_DESEL: begin
        if (st.win != '0) begin
          // own select drive may still sit in the synchroniser
          next_st.win = st.win - `SPS_CNT_W'(1);
        end else if (sel) begin
          next_st.fsm = SPS_SEL;
          next_st.bitc = 3'h0;
          next_st.tx_sh = buf_valid ? buf_data : '0;
        end else if (i_req) begin
          next_st.fsm = SPS_PROACT;
          next_st.win = `SPS_CNT_W'(`SPS_T2_CYC);
        end else if (i_psave_req) begin
          next_st.fsm = SPS_PSAVE;
        end
      end
      SPS_SEL: begin
        if (!sel) begin
          next_st.fsm = SPS_DESEL;
        end else begin
          if (rise) begin
            // sample on rising edge, mode 0
            next_st.rx_sh = {st.rx_sh[`SPS_DW-2:0], st.mosi_s[1]};
            next_st.bitc = st.bitc + 3'h1;
            if (st.bitc == `SPS_BIT_LAST) begin
              next_st.rx_v = 1'b1;
              next_st.rx_d = {st.rx_sh[`SPS_DW-2:0], st.mosi_s[1]};
            end
          end
          if (fall) begin
            // shift out on falling edge; reload at byte end
            if (st.bitc == 3'h0) begin
              next_st.tx_sh = buf_valid ? buf_data : '0;
            end else begin
              next_st.tx_sh = {st.tx_sh[`SPS_DW-2:0], 1'b0};
            end
          end
        end
      end
      SPS_PROACT: begin
        // window closes on master select or timeout; on the four-wire
        // link a low line is our own drive, so a master joining in
        // is served only once the window has run out
        if (sel && !st.ss_oe) begin
          next_st.fsm = SPS_SEL;
          next_st.bitc = 3'h0;
          next_st.tx_sh = buf_valid ? buf_data : '0;
          next_st.win = '0;
        end else if (st.win <= `SPS_CNT_W'(1)) begin
          next_st.fsm = SPS_DESEL;
          next_st.win = `SPS_CNT_W'(`SPS_SETTLE_CYC);
        end else begin
          next_st.win = st.win - `SPS_CNT_W'(1);
        end
      end
      SPS_PSAVE: begin
        // select leading edge resumes the slave
        if (sel) begin
          next_st.fsm = SPS_SEL;
          next_st.bitc = 3'h0;
          // no stale shifter content from before the sleep
          next_st.tx_sh = buf_valid ? buf_data : '0;
        end
      end
      default: begin
        next_st.fsm = SPS_INIT;
      end
    endcase
    // pin enables registered from the next state, plus i_four_wire for select and attention
    next_st.miso_oe = miso_allowed(next_st.fsm);
    next_st.miso = miso_allowed(next_st.fsm) ?
      next_st.tx_sh[`SPS_DW-1] : 1'b0;
    // four-wire: slave pulls select low itself when pro-active
    next_st.ss_oe = i_four_wire && (next_st.fsm == SPS_PROACT);
    next_st.ss_o = 1'b0; // never driven while de-selected
    // five-wire attention line, low during request window only
    next_st.attn_oe = !i_four_wire && (next_st.fsm == SPS_PROACT);
    next_st.attn = !next_st.attn_oe;
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '0;
      st.fsm <= SPS_INIT;
      st.ss_s <= 2'h3;
      st.attn <= 1'b1;
      st.ss_o <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_miso = st.miso;
  assign o_miso_oe = st.miso_oe;
  assign o_slave_select_line = st.ss_o;
  assign o_slave_select_line_oe = st.ss_oe;
  assign o_attn_n = st.attn;
  assign o_attn_oe = st.attn_oe;
  assign o_rx_valid = st.rx_v;
  assign o_rx_data = st.rx_d;
  assign o_state = st.fsm;

  // serial output enabled only in selected state
  chk_miso_only_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st.miso_oe |-> st.fsm == SPS_SEL) else $error("miso driven off sel");
  // initial state never drives output
  chk_init_hiz: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st.fsm == SPS_INIT |-> !st.miso_oe) else $error("miso driven in init");
  // stays initial without configuration done
  chk_init_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st.fsm == SPS_INIT && !i_cfg_done |=> st.fsm == SPS_INIT)
    else $error("left init early");
  // attention only while pro-active
  chk_attn_window: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st.attn_oe |-> st.fsm == SPS_PROACT && !st.attn)
    else $error("attention outside window");
  // pro-active ends within the window
  sequence s_enter_proact;
    st.fsm != SPS_PROACT ##1 st.fsm == SPS_PROACT;
  endsequence
  chk_window_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_enter_proact |-> ##[1:101] st.fsm != SPS_PROACT)
    else $error("request window overrun");
  // slave drives select only in four-wire pro-active
  chk_ss_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st.ss_oe |-> st.fsm == SPS_PROACT && !st.ss_o)
    else $error("select driven wrongly");
  // own select drive never mistaken for a master select
  chk_own_select: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st.fsm == SPS_PROACT && st.ss_oe |=> st.fsm != SPS_SEL)
    else $error("own select taken as master");
  // de-selected leaves select undriven
  chk_desel_ss: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st.fsm == SPS_DESEL |-> !st.ss_oe && !st.miso_oe)
    else $error("desel pins driven");
  // serial output enable tracks the state register one to one
  chk_oe_decode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $changed(st.fsm) |-> st.miso_oe == (st.fsm == SPS_SEL))
    else $error("enable not decoded");
endmodule

// ===== hdl/sps_params.svh
// constants for the slave pin-state manager
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
`define SPS_CLK_NS 10
`define SPS_T2_NS 1000
`define SPS_T2_CYC ((`SPS_T2_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`define SPS_CNT_W 8
`define SPS_DW 8
`define SPS_BUF_DEPTH 2
`define SPS_BIT_LAST 3'h7
`define SPS_SETTLE_CYC 3
`endif

// ===== hdl/sps_pkg.sv
// types for the slave pin-state manager
package sps_pkg;
  typedef enum logic [2:0] {
    SPS_INIT, SPS_DESEL, SPS_SEL, SPS_PROACT, SPS_PSAVE
  } sps_state_t;
endpackage

// ===== hdl/sps_buf.sv
// two-entry valid/ready buffer for the transmit data path
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_buf (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [`SPS_DW-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [`SPS_DW-1:0] o_out_data
);
  import sps_pkg::*;
  typedef struct packed {
    logic [1:0][`SPS_DW-1:0] mem; // two slots, slot 0 is head
    logic [1:0] cnt; // number of words held
    logic rdy; // room flag, registered so ready is glitch free
  } sps_buf_st_t;
  sps_buf_st_t st;
  sps_buf_st_t next_st;
  logic push;
  logic pop;

  // handshakes on both sides
  always_comb begin
    push = i_in_valid && st.rdy;
    pop = (st.cnt != 2'h0) && i_out_ready;
  end

  // shift-down buffer; pop and push in one cycle are fine
  always_comb begin
    next_st = st;
    if (pop) begin
      next_st.mem[0] = st.mem[1];
    end
    if (push) begin
      // land the word in the first free slot after any pop
      if ((st.cnt - {1'b0, pop}) == 2'h0) begin
        next_st.mem[0] = i_in_data;
      end else begin
        next_st.mem[1] = i_in_data;
      end
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
    // room follows the count it will have after this edge
    next_st.rdy = (next_st.cnt != 2'(`SPS_BUF_DEPTH));
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '{mem: '0, cnt: 2'h0, rdy: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign o_in_ready = st.rdy;
  assign o_out_valid = (st.cnt != 2'h0);
  assign o_out_data = st.mem[0];
endmodule

// ===== testbench/sps_master_model.sv
// spi master model for the slave pin-state manager
`timescale 1ns/10ps
module sps_master_model (
  output logic o_sck,
  output logic o_mosi,
  output logic o_ss_n,
  input wire logic i_miso
);
  // mode 0 idle: clock low and still outside frames
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_ss_n = 1'b1;
  end
  // one frame of two bytes, msb first, 160 ns link clock
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    o_ss_n = 1'b0;
    #240;
    for (int b = 15; b >= 0; b--) begin
      o_mosi = tx[b];
      #80 o_sck = 1'b1;
      rx[b] = i_miso;
      #80 o_sck = 1'b0;
    end
    #240 o_ss_n = 1'b1;
    // line now serves other slaves, so never a held value
    o_mosi = ~o_mosi;
  endtask
endmodule

// ===== testbench/sps_top_bench.sv
// self-checking bench for the slave pin-state manager
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_top_bench;
  import sps_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0; // reset held at start
  logic four = 1'b0, cfg = 1'b0, req = 1'b0, ps = 1'b0, tx_valid = 1'b0;
  logic tx_ready, rx_valid, miso, miso_oe, ss, ss_oe, attn_n, attn_oe;
  logic m_sck, m_mosi, m_ss_n, ss_line, miso_line;
  logic [`SPS_DW-1:0] tx_data = 8'h00, rx_data;
  sps_state_t state;
  int mismatches = 0, checked = 0, cycles = 0;
  always #5 i_clk = ~i_clk; // 100 MHz
  // wired-and select line; data out pulled up when floating
  assign ss_line = m_ss_n & (ss_oe ? ss : 1'b1);
  assign miso_line = miso_oe ? miso : 1'b1;
  sps_top sps_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_four_wire(four),
    .i_cfg_done(cfg), .i_req(req), .i_psave_req(ps), .i_sck(m_sck),
    .i_mosi(m_mosi), .i_slave_select_line(ss_line), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .i_tx_data(tx_data), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .o_miso(miso), .o_miso_oe(miso_oe),
    .o_slave_select_line(ss), .o_slave_select_line_oe(ss_oe),
    .o_attn_n(attn_n), .o_attn_oe(attn_oe), .o_state(state));
  sps_master_model sps_master_model_i (.o_sck(m_sck), .o_mosi(m_mosi),
    .o_ss_n(m_ss_n), .i_miso(miso_line));
  // compare and count
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // state and the three pin enables together
  task automatic pins(input sps_state_t st, input logic [2:0] oe);
    chk("state", {5'h00, st}, {5'h00, state});
    chk("oe", {5'h00, oe}, {5'h00, miso_oe, attn_oe, ss_oe});
  endtask
  task automatic complete_run;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard, far above the planned run
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  // one word into the buffer, waits for acceptance
  task automatic push(input logic [7:0] w);
    logic r;
    int n;
    n = 0;
    @(posedge i_clk) tx_valid <= 1'b1;
    tx_data <= w;
    do begin
      @(negedge i_clk) r = tx_ready;
      @(posedge i_clk);
      n++;
    end while (r !== 1'b1 && n < 50);
    tx_valid <= 1'b0;
    chk("accept", 8'h01, {7'h00, r});
  endtask
  // two-byte frame; both bytes received and the buffered words seen on miso
  task automatic t_xfer(input logic [15:0] mo, input logic [15:0] ex);
    logic [15:0] got;
    int n;
    fork
      sps_master_model_i.xfer(mo, got);
      for (int k = 1; k >= 0; k--) begin
        n = 0;
        do begin
          @(negedge i_clk);
          n++;
        end while (rx_valid !== 1'b1 && n < 400);
        chk("rx_valid", 8'h01, {7'h00, rx_valid});
        chk("rx", mo[8*k+:8], rx_data);
        pins(SPS_SEL, 3'b100);
        @(negedge i_clk);
      end
    join
    chk("miso_hi", ex[15:8], got[15:8]);
    chk("miso_lo", ex[7:0], got[7:0]);
    repeat (6) @(negedge i_clk);
    pins(SPS_DESEL, 3'b000);
  endtask
  // attention request; window length on the four- or five-signal link chosen by f
  task automatic t_proact(input logic f);
    int n;
    n = 0;
    @(posedge i_clk) four <= f;
    req <= 1'b1;
    repeat (2) @(negedge i_clk);
    pins(SPS_PROACT, f ? 3'b001 : 3'b010);
    chk("level", 8'h00, {7'h00, f ? ss : attn_n});
    @(posedge i_clk) req <= 1'b0;
    while ((attn_oe | ss_oe) === 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    chk("window", 8'h01, {7'h00, n >= 90 && n <= 100});
    repeat (20) @(negedge i_clk);
    pins(SPS_DESEL, 3'b000);
    @(posedge i_clk) four <= 1'b0;
  endtask
  initial begin
    repeat (2) @(negedge i_clk);
    pins(SPS_INIT, 3'b000);
    @(posedge i_clk) i_rst_n <= 1'b1;
    repeat (6) @(negedge i_clk);
    pins(SPS_INIT, 3'b000);
    @(posedge i_clk) cfg <= 1'b1;
    repeat (2) @(negedge i_clk);
    pins(SPS_DESEL, 3'b000);
    push(8'h3C);
    push(8'hC3);
    // third word must be refused while two are held
    @(posedge i_clk) tx_valid <= 1'b1;
    tx_data <= 8'h77;
    repeat (4) begin
      @(negedge i_clk);
      chk("full", 8'h00, {7'h00, tx_ready});
    end
    @(posedge i_clk) tx_valid <= 1'b0;
    t_xfer(16'hA55A, 16'h3CC3);
    t_xfer(16'h8118, 16'h0000);
    t_proact(1'b0);
    t_proact(1'b1);
    push(8'h5A);
    @(posedge i_clk) ps <= 1'b1;
    repeat (2) @(negedge i_clk);
    pins(SPS_PSAVE, 3'b000);
    @(posedge i_clk) ps <= 1'b0;
    t_xfer(16'h6699, 16'h5A00);
    complete_run();
  end
endmodule
